/* File: design/fpa_pkg.sv */
// Constants and parameter tables of the fieldbus parameter-access block
// Summary of operation
// - Every accepted parameter request gets a reply of exactly four words.
// - Operation codes 1/2 read integer/float, 3/4 write integer/float.
// - A refused request sets the top bit of reply word one, error in word three.
// - Reply word two echoes the identifier of the parameter that was handled.
// - On success word three holds the value's upper half, word four its lower half.
// - Error codes: 2 unknown parameter, 3 unknown operation, 4 read-only, 7 buffer, 10 range.
// - Fieldbus protocol setting: 0 off, 1 DP, 2 IO, 3 Ethernet based; default off.
// - Node address setting accepts 3 to 127, default 3.
// - Loss-of-communication timeout settable 0.01 s to 10 s, default 0.01 s.
// - Freeze enable holds last valid speed reference and command word during loss.
// - After communication resumes, new commands wait a settable 0 to 10 s delay.
// - Message layout setting selects layouts 1 to 5, default layout 5.
// - Input word three select codes: 0-9, 21 and 65-68 as listed.
// - Input words four and five have their own select settings, default off.
// - Modbus enable: 0 off, 1 RTU, 2 TCP, 3 both; default off.
// - Alarm 53 when Modbus idle beyond 0-250 s timeout, default 3 s, 0 disables.
// - Modbus input exchange area: 0 none, 1 one area, 2 two areas; default off.
// - Parameter words exist only with message layouts 1, 2 and 5.
`default_nettype none
package fpa_pkg;
  localparam int NPAR = 14;
  localparam int NSET = 12;
  localparam int CNT_W = 15;
  // Parameter table indices
  localparam logic [3:0] IX_FB_SEL  = 4'h0;
  localparam logic [3:0] IX_NODE    = 4'h1;
  localparam logic [3:0] IX_FB_TMO  = 4'h2;
  localparam logic [3:0] IX_FREEZE  = 4'h3;
  localparam logic [3:0] IX_DELAY   = 4'h4;
  localparam logic [3:0] IX_LAYOUT  = 4'h5;
  localparam logic [3:0] IX_IW3     = 4'h6;
  localparam logic [3:0] IX_IW4     = 4'h7;
  localparam logic [3:0] IX_IW5     = 4'h8;
  localparam logic [3:0] IX_MB_EN   = 4'h9;
  localparam logic [3:0] IX_MB_TMO  = 4'ha;
  localparam logic [3:0] IX_MB_AREA = 4'hb;
  localparam logic [3:0] IX_STATUS  = 4'hc;
  localparam logic [3:0] IX_BUF     = 4'hd;
  // Identifiers: group*100+index in decimal
  localparam logic [15:0] PAR_ID [NPAR] = '{16'h1fa5, 16'h1fa6, 16'h1fa7, 16'h1fa8,
    16'h1fa9, 16'h1fb8, 16'h1fb9, 16'h1fba, 16'h1fbb, 16'h2009, 16'h200d, 16'h200f,
    16'h2007, 16'h1fc2};
  localparam logic [15:0] PAR_MIN [NSET] = '{16'h0000, 16'h0003, 16'h0001, 16'h0000,
    16'h0000, 16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
  localparam logic [15:0] PAR_MAX [NSET] = '{16'h0003, 16'h007f, 16'h03e8, 16'h0001,
    16'h03e8, 16'h0005, 16'h0044, 16'h0044, 16'h0044, 16'h0003, 16'h00fa, 16'h0002};
  localparam logic [15:0] PAR_DEF [NSET] = '{16'h0000, 16'h0003, 16'h0001, 16'h0000,
    16'h0000, 16'h0005, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0003, 16'h0000};
  // Input word select codes
  localparam logic [15:0] IW_LOW_LAST  = 16'h0009;
  localparam logic [15:0] IW_TRQ_FFW   = 16'h0015;
  localparam logic [15:0] IW_PID_FIRST = 16'h0041;
  localparam logic [15:0] IW_PID_LAST  = 16'h0044;
  // Message layouts that carry parameter words
  localparam logic [15:0] LAYOUT_1 = 16'h0001;
  localparam logic [15:0] LAYOUT_2 = 16'h0002;
  localparam logic [15:0] LAYOUT_5 = 16'h0005;
  // Operation codes and error codes
  localparam logic [14:0] OP_RD_INT = 15'h0001;
  localparam logic [14:0] OP_RD_FLT = 15'h0002;
  localparam logic [14:0] OP_WR_INT = 15'h0003;
  localparam logic [14:0] OP_WR_FLT = 15'h0004;
  localparam int          REJECT_BIT = 15;
  localparam logic [15:0] ERR_NO_PAR = 16'h0002;
  localparam logic [15:0] ERR_NO_OP  = 16'h0003;
  localparam logic [15:0] ERR_RO     = 16'h0004;
  localparam logic [15:0] ERR_BUF    = 16'h0007;
  localparam logic [15:0] ERR_RANGE  = 16'h000a;
  // Bus register byte offsets
  localparam logic [7:0] A_REQ_OP = 8'h00;
  localparam logic [7:0] A_REQ_ID = 8'h04;
  localparam logic [7:0] A_REQ_HI = 8'h08;
  localparam logic [7:0] A_REQ_LO = 8'h0c;
  localparam logic [7:0] A_CTRL   = 8'h10;
  localparam logic [7:0] A_RSP_OP = 8'h14;
  localparam logic [7:0] A_RSP_ID = 8'h18;
  localparam logic [7:0] A_RSP_HI = 8'h1c;
  localparam logic [7:0] A_RSP_LO = 8'h20;
  localparam logic [7:0] A_STATUS = 8'h24;
  localparam int CTRL_GO = 0;
  localparam int ST_DONE = 0;
  localparam int ST_LOST = 1;
  localparam int ST_MB_ALARM = 2;
  localparam int ST_PKW_EN = 3;
  localparam int ST_RECOVER = 4;
  localparam int CMD_VALID_BIT = 10;
  // Timing: one tick per 0.01 s
  localparam int TICK_MS = 10;
  localparam int CLK_KHZ = 125000;
  localparam int TICK_CYCLES = TICK_MS * CLK_KHZ;
  localparam logic [CNT_W-1:0] TICKS_PER_S = 15'd100;
endpackage
`default_nettype wire

/* File: design/fpa_tick.sv */
// Divider giving a one-cycle enable every 0.01 s
`default_nettype none
`timescale 1ns/10ps
module fpa_tick #(
  parameter int DIV = 1250000
) (
  // Clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // Enable pulse
  output logic      tick
);
  logic [20:0] cnt_r;
  logic        tick_r;
  wire         wrap = (cnt_r == 21'(DIV - 1));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r  <= 21'h0;
      tick_r <= 1'b0;
    end else begin
      cnt_r  <= wrap ? 21'h0 : cnt_r + 21'h1;
      tick_r <= wrap;
    end
  end
  assign tick = tick_r;
endmodule
`default_nettype wire

/* File: design/fpa_timer.sv */
// Saturating tick counter that restarts on activity and flags expiry
`default_nettype none
`timescale 1ns/10ps
module fpa_timer
  import fpa_pkg::*;
(
  // Clock and reset
  input  wire logic             hclk,
  input  wire logic             hresetn,
  // Control
  input  wire logic             tick,
  input  wire logic             restart,
  input  wire logic [CNT_W-1:0] limit,
  // Status
  output logic                  expired
);
  logic [CNT_W-1:0] cnt_r;
  wire              at_max = &cnt_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= '0;
    end else if (restart) begin
      cnt_r <= '0;
    end else if (tick && !at_max) begin
      cnt_r <= cnt_r + 15'h1;
    end
  end
  // Beyond limit ticks, so a tick just after restart cannot expire it early
  assign expired = (limit == '0) || (cnt_r > limit);
endmodule
`default_nettype wire

/* File: design/fpa_top.sv */
// Parameter-access interpreter with fieldbus and Modbus settings, AHB-Lite slave
`default_nettype none
`timescale 1ns/10ps
module fpa_top
  import fpa_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYCLES
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Cyclic fieldbus data
  input  wire logic        fb_frame,
  input  wire logic [15:0] fb_cmd_word,
  input  wire logic [15:0] fb_speed_ref,
  output logic [15:0]      cmd_word_out,
  output logic [15:0]      speed_ref_out,
  output logic             fb_comm_lost,
  // Modbus activity and alarm
  input  wire logic        mb_activity,
  output logic             mb_alarm53,
  // Current settings
  output logic [1:0]       fieldbus_protocol,
  output logic [6:0]       node_address,
  output logic [2:0]       message_layout_select,
  output logic [6:0]       input_word3_select,
  output logic [6:0]       input_word4_select,
  output logic [6:0]       input_word5_select,
  output logic [1:0]       modbus_mode,
  output logic [1:0]       modbus_exchange_area
);
  // Parameter identifier lookup: {found, index}
  function automatic logic [4:0] par_find(input logic [15:0] id);
    par_find = 5'h0;
    for (int i = 0; i < NPAR; i++) begin
      if (id == PAR_ID[i]) par_find = {1'b1, 4'(i)};
    end
  endfunction

  function automatic logic iw_code_ok(input logic [15:0] v);
    iw_code_ok = (v <= IW_LOW_LAST) || (v == IW_TRQ_FFW) ||
                 ((v >= IW_PID_FIRST) && (v <= IW_PID_LAST));
  endfunction

  function automatic logic [31:0] int_to_flt(input logic [15:0] v);
    logic [4:0]  p;
    logic [31:0] m;
    p = 5'h0;
    for (int i = 0; i < 16; i++) begin
      if (v[i]) p = 5'(i);
    end
    m = {16'h0, v} << (5'd23 - p);
    int_to_flt = (v == 16'h0) ? 32'h0 : {1'b0, 8'd127 + {3'b0, p}, m[22:0]};
  endfunction

  // Negative or too large values map to all ones so the range check refuses them
  function automatic logic [31:0] flt_to_int(input logic [31:0] f);
    logic [7:0]  e;
    logic [31:0] m;
    e = f[30:23];
    m = {8'h0, 1'b1, f[22:0]};
    if (f[30:0] == 31'h0) flt_to_int = 32'h0;
    else if (f[31] || e > 8'd142) flt_to_int = 32'hffffffff;
    else if (e < 8'd127) flt_to_int = 32'h0;
    else flt_to_int = m >> (8'd150 - e);
  endfunction

  // Bus slave: address phase capture, zero wait states
  logic        wr_pend_r;
  logic [7:0]  waddr_r;
  logic [31:0] hrdata_r;
  logic [15:0] req_op_r, req_id_r, req_hi_r, req_lo_r;
  logic [15:0] rsp_op_r, rsp_id_r, rsp_hi_r, rsp_lo_r;
  logic        done_r;
  logic [15:0] set_r [NSET];

  wire       addr_ok = hsel && hready && htrans[1];
  wire       wr_en   = wr_pend_r;
  wire [7:0] raddr   = haddr[7:0];
  wire       go      = wr_en && (waddr_r == A_CTRL) && hwdata[CTRL_GO];

  // Status flags
  logic recover_r;
  wire  mb_alarm;
  wire  comm_lost;
  wire  [15:0] layout = set_r[IX_LAYOUT];
  // parameter words only in layouts 1, 2 and 5
  wire  pkw_en = (layout == LAYOUT_1) || (layout == LAYOUT_2) || (layout == LAYOUT_5);
  wire  [15:0] status_w = {11'h0, recover_r, pkw_en, mb_alarm, comm_lost, done_r};

  wire [31:0] rd_mux =
    (raddr == A_REQ_OP) ? {16'h0, req_op_r} :
    (raddr == A_REQ_ID) ? {16'h0, req_id_r} :
    (raddr == A_REQ_HI) ? {16'h0, req_hi_r} :
    (raddr == A_REQ_LO) ? {16'h0, req_lo_r} :
    (raddr == A_RSP_OP) ? {16'h0, rsp_op_r} :
    (raddr == A_RSP_ID) ? {16'h0, rsp_id_r} :
    (raddr == A_RSP_HI) ? {16'h0, rsp_hi_r} :
    (raddr == A_RSP_LO) ? {16'h0, rsp_lo_r} :
    (raddr == A_STATUS) ? {16'h0, status_w} : 32'h0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      waddr_r   <= 8'h0;
      hrdata_r  <= 32'h0;
    end else begin
      wr_pend_r <= addr_ok && hwrite;
      waddr_r   <= raddr;
      hrdata_r  <= (addr_ok && !hwrite) ? rd_mux : 32'h0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_op_r <= 16'h0;
      req_id_r <= 16'h0;
      req_hi_r <= 16'h0;
      req_lo_r <= 16'h0;
    end else if (wr_en) begin
      if (waddr_r == A_REQ_OP) req_op_r <= hwdata[15:0];
      if (waddr_r == A_REQ_ID) req_id_r <= hwdata[15:0];
      if (waddr_r == A_REQ_HI) req_hi_r <= hwdata[15:0];
      if (waddr_r == A_REQ_LO) req_lo_r <= hwdata[15:0];
    end
  end

  assign hrdata    = hrdata_r;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Request decode
  // code below flag
  wire [14:0] op       = req_op_r[14:0];
  wire        op_rd    = (op == OP_RD_INT) || (op == OP_RD_FLT);
  wire        op_wr    = (op == OP_WR_INT) || (op == OP_WR_FLT);
  wire        op_flt   = (op == OP_RD_FLT) || (op == OP_WR_FLT);
  wire [4:0]  found    = par_find(req_id_r);
  wire [3:0]  idx      = found[3:0];
  wire        is_set   = found[4] && (idx < 4'(NSET));
  wire        is_iw    = (idx == IX_IW3) || (idx == IX_IW4) || (idx == IX_IW5);
  // value words only taken for write codes
  wire [31:0] wr_val   = op_flt ? flt_to_int({req_hi_r, req_lo_r}) : {req_hi_r, req_lo_r};
  wire [15:0] wr16     = wr_val[15:0];
  wire [15:0] lim_min  = is_set ? PAR_MIN[idx] : 16'h0;
  wire [15:0] lim_max  = is_set ? PAR_MAX[idx] : 16'h0;
  wire        in_range = (wr_val[31:16] == 16'h0) && (wr16 >= lim_min) &&
                         (wr16 <= lim_max) && (!is_iw || iw_code_ok(wr16));
  wire [15:0] rd16     = (idx == IX_STATUS) ? status_w :
                         (idx == IX_BUF)    ? set_r[IX_IW3] :
                         is_set             ? set_r[idx] : 16'h0;
  wire [31:0] rd_val   = op_flt ? int_to_flt(rd16) : {16'h0, rd16};

  wire [15:0] err_code =
    !(op_rd || op_wr)                   ? ERR_NO_OP  :
    !found[4]                           ? ERR_NO_PAR :
    (op_wr && (idx == IX_STATUS))       ? ERR_RO     :
    (op_wr && (idx == IX_BUF))          ? ERR_BUF    :
    (op_wr && !in_range)                ? ERR_RANGE  : 16'h0;
  wire        refuse   = (err_code != 16'h0) || req_op_r[REJECT_BIT];
  wire [15:0] err_fix  = (err_code != 16'h0) ? err_code : ERR_NO_OP;
  wire        run      = go && pkw_en;
  wire        wr_ok    = run && op_wr && !refuse && is_set;
  wire [31:0] ok_val   = op_wr ? wr_val : rd_val;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rsp_op_r <= 16'h0;
      rsp_id_r <= 16'h0;
      rsp_hi_r <= 16'h0;
      rsp_lo_r <= 16'h0;
    end else if (run) begin
      rsp_op_r <= {refuse, op};
      rsp_id_r <= req_id_r;
      rsp_hi_r <= refuse ? err_fix : ok_val[31:16];
      rsp_lo_r <= refuse ? 16'h0 : ok_val[15:0];
    end
  end

  // each new go restarts the exchange; done shows the reply is valid
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done_r <= 1'b0;
    end else if (go) begin
      done_r <= pkw_en;
    end
  end

  generate
    for (genvar g = 0; g < NSET; g++) begin : g_set
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          set_r[g] <= PAR_DEF[g];
        end else if (wr_ok && (idx == 4'(g))) begin
          set_r[g] <= wr16;
        end
      end
    end
  endgenerate

  // Timers on a 0.01 s tick
  wire tick;
  wire fb_exp, dly_exp, mb_exp;
  wire [CNT_W-1:0] mb_limit = 15'(set_r[IX_MB_TMO] * TICKS_PER_S);

  fpa_tick #(.DIV(TICK_DIV)) u_tick (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tick    (tick)
  );

  fpa_timer u_fb_timer (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tick    (tick),
    .restart (fb_frame),
    .limit   (set_r[IX_FB_TMO][CNT_W-1:0]),
    .expired (fb_exp)
  );

  // restore delay starts with the first frame after a loss
  fpa_timer u_dly_timer (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tick    (tick),
    .restart (fb_frame && comm_lost),
    .limit   (set_r[IX_DELAY][CNT_W-1:0]),
    .expired (dly_exp)
  );

  fpa_timer u_mb_timer (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tick    (tick),
    .restart (mb_activity),
    .limit   (mb_limit),
    .expired (mb_exp)
  );

  assign comm_lost = fb_exp && (set_r[IX_FB_SEL] != 16'h0);
  // zero timeout or Modbus off disables the alarm
  assign mb_alarm  = mb_exp && (set_r[IX_MB_TMO] != 16'h0) && (set_r[IX_MB_EN] != 16'h0);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      recover_r <= 1'b0;
    end else if (fb_frame && comm_lost) begin
      recover_r <= 1'b1;
    end else if (dly_exp) begin
      recover_r <= 1'b0;
    end
  end

  // freeze: keep last valid values while lost or marked invalid
  wire freeze_en = set_r[IX_FREEZE][0];
  wire in_valid  = !freeze_en || fb_cmd_word[CMD_VALID_BIT];
  wire apply     = fb_frame && !comm_lost && !recover_r && in_valid;
  wire drop      = comm_lost && !freeze_en;
  logic [15:0] cmd_r, ref_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_r <= 16'h0;
      ref_r <= 16'h0;
    end else if (drop) begin
      cmd_r <= 16'h0;
      ref_r <= 16'h0;
    end else if (apply) begin
      cmd_r <= fb_cmd_word;
      ref_r <= fb_speed_ref;
    end
  end

  assign cmd_word_out          = cmd_r;
  assign speed_ref_out         = ref_r;
  assign fb_comm_lost          = comm_lost;
  assign mb_alarm53            = mb_alarm;
  assign fieldbus_protocol     = set_r[IX_FB_SEL][1:0];
  assign node_address          = set_r[IX_NODE][6:0];
  assign message_layout_select = set_r[IX_LAYOUT][2:0];
  assign input_word3_select    = set_r[IX_IW3][6:0];
  assign input_word4_select    = set_r[IX_IW4][6:0];
  assign input_word5_select    = set_r[IX_IW5][6:0];
  assign modbus_mode           = set_r[IX_MB_EN][1:0];
  assign modbus_exchange_area  = set_r[IX_MB_AREA][1:0];

  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_go_ok;
    go && pkw_en && !refuse;
  endsequence

  reply_done_a: assert property (go && pkw_en |=> done_r)
    else $error("reply not marked done after request");
  op_echo_a: assert property (s_go_ok |=> rsp_op_r == {1'b0, $past(op)})
    else $error("operation code not echoed");
  reject_flag_a: assert property (go && pkw_en && !(op_rd || op_wr) |=>
    rsp_op_r[REJECT_BIT] && rsp_hi_r == ERR_NO_OP)
    else $error("unknown operation not refused");
  id_echo_a: assert property (go && pkw_en |=> rsp_id_r == $past(req_id_r))
    else $error("identifier not echoed");
  read_value_a: assert property (s_go_ok ##0 (op == OP_RD_INT && idx == IX_NODE) |=>
    rsp_hi_r == 16'h0 && rsp_lo_r == set_r[IX_NODE])
    else $error("read value halves wrong");
  unknown_par_a: assert property (go && pkw_en && op_rd && !found[4] |=>
    rsp_hi_r == ERR_NO_PAR && rsp_lo_r == 16'h0)
    else $error("unknown parameter code wrong");
  node_range_a: assert property (set_r[IX_NODE] >= 16'h0003 &&
    set_r[IX_NODE] <= 16'h007f)
    else $error("node address out of range");
  freeze_hold_a: assert property (freeze_en && comm_lost |=> $stable(cmd_r))
    else $error("frozen command word changed");
  mb_off_a: assert property (set_r[IX_MB_TMO] == 16'h0 |-> !mb_alarm53)
    else $error("alarm with zero timeout");
  no_pkw_a: assert property (go && !pkw_en |=> !done_r && $stable(rsp_op_r))
    else $error("reply given without parameter words");
endmodule
`default_nettype wire

/* File: testbench/fpa_far_model.sv */
// Far-side model: cyclic fieldbus frames and Modbus traffic
`timescale 1ns/10ps
`default_nettype none
module fpa_far_model #(
  parameter int FB_PER = 5,
  parameter int MB_PER = 50
) (
  // Clock
  input  wire logic        hclk,
  // Traffic control
  input  wire logic        fb_run,
  input  wire logic        mb_run,
  input  wire logic [15:0] cmd,
  input  wire logic [15:0] ref_val,
  // Lines into the block
  output logic             fb_frame,
  output logic [15:0]      fb_cmd_word,
  output logic [15:0]      fb_speed_ref,
  output logic             mb_activity
);
  int  fb_cnt;
  int  mb_cnt;
  wire send = fb_run && fb_cnt == 0;
  initial begin
    fb_cnt = 0;
    mb_cnt = 0;
    fb_frame = 1'b0;
    fb_cmd_word = 16'h0000;
    fb_speed_ref = 16'h0000;
    mb_activity = 1'b0;
  end
  always @(posedge hclk) begin
    fb_cnt <= (fb_cnt + 1) % FB_PER;
    mb_cnt <= (mb_cnt + 1) % MB_PER;
    fb_frame <= send;
    // Words are meaningless between frames, so they keep toggling
    fb_cmd_word <= send ? cmd : ~fb_cmd_word;
    fb_speed_ref <= send ? ref_val : ~fb_speed_ref;
    mb_activity <= mb_run && mb_cnt == 0;
  end
endmodule
`default_nettype wire

/* File: testbench/tb.sv */
// Self-checking bench for the fieldbus parameter-access block
`timescale 1ns/10ps
`default_nettype none
module tb;
  import fpa_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans, fbp, mbm, mba;
  logic        fb_frame, mb_activity, fb_comm_lost, mb_alarm53;
  logic        fb_run, mb_run;
  logic [15:0] cmd, ref_val, fcw, fsr, cwo, sro;
  logic [6:0]  node, iw3, iw4, iw5;
  logic [2:0]  lay;
  logic [15:0] rsp [4];
  int          n_errors = 0;
  int          num_checks = 0;

  fpa_top #(.TICK_DIV(20)) u_fpa_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .fb_frame(fb_frame), .fb_cmd_word(fcw), .fb_speed_ref(fsr), .cmd_word_out(cwo),
    .speed_ref_out(sro), .fb_comm_lost(fb_comm_lost), .mb_activity(mb_activity),
    .mb_alarm53(mb_alarm53), .fieldbus_protocol(fbp), .node_address(node),
    .message_layout_select(lay), .input_word3_select(iw3), .input_word4_select(iw4),
    .input_word5_select(iw5), .modbus_mode(mbm), .modbus_exchange_area(mba));
  fpa_far_model u_fpa_far_model (.hclk(hclk), .fb_run(fb_run), .mb_run(mb_run),
    .cmd(cmd), .ref_val(ref_val), .fb_frame(fb_frame), .fb_cmd_word(fcw),
    .fb_speed_ref(fsr), .mb_activity(mb_activity));

  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask

  task automatic pkw(input logic [15:0] op, id, hi, lo);
    logic [31:0] q;
    bus(1'b1, A_REQ_OP, {16'h0, op}, q);
    bus(1'b1, A_REQ_ID, {16'h0, id}, q);
    if (op == 16'h3 || op == 16'h4) begin
      bus(1'b1, A_REQ_HI, {16'h0, hi}, q);
      bus(1'b1, A_REQ_LO, {16'h0, lo}, q);
    end
    bus(1'b1, A_CTRL, 32'h1, q);
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, A_RSP_OP + 8'(4 * i), 32'h0, q);
      rsp[i] = q[15:0];
    end
  endtask

  task automatic set(input logic [15:0] id, val);
    pkw(16'h3, id, 16'h0, val);
    check("set op", rsp[0], 16'h3);
  endtask

  task automatic t_reads();
    check("protocol", 16'(fbp), 16'h0);
    check("node", 16'(node), 16'h3);
    check("layout", 16'(lay), 16'h5);
    check("iw4", 16'(iw4), 16'h0);
    check("iw5", 16'(iw5), 16'h0);
    check("modbus", 16'(mbm), 16'h0);
    check("area", 16'(mba), 16'h0);
    pkw(16'h1, PAR_ID[IX_NODE], 16'h0, 16'h0);
    check("rd op", rsp[0], 16'h1);
    check("rd id", rsp[1], PAR_ID[IX_NODE]);
    check("rd hi", rsp[2], 16'h0);
    check("rd lo", rsp[3], 16'h3);
    pkw(16'h2, PAR_ID[IX_NODE], 16'h0, 16'h0);
    check("fl hi", rsp[2], 16'h4040);
    check("fl lo", rsp[3], 16'h0);
    pkw(16'h1, PAR_ID[IX_FB_TMO], 16'h0, 16'h0);
    check("fb tmo", rsp[3], 16'h1);
    pkw(16'h1, PAR_ID[IX_MB_TMO], 16'h0, 16'h0);
    check("mb tmo", rsp[3], 16'h3);
  endtask

  task automatic t_refuse();
    logic [15:0] op [7] = '{16'h5, 16'h8001, 16'h1, 16'h3, 16'h3, 16'h3, 16'h3};
    logic [15:0] id [7] = '{PAR_ID[IX_NODE], PAR_ID[IX_NODE], 16'h1234,
      PAR_ID[IX_STATUS], PAR_ID[IX_BUF], PAR_ID[IX_NODE], PAR_ID[IX_IW3]};
    logic [15:0] lo [7] = '{16'h0, 16'h0, 16'h0, 16'h1, 16'h1, 16'h80, 16'ha};
    logic [15:0] ec [7] = '{ERR_NO_OP, ERR_NO_OP, ERR_NO_PAR, ERR_RO, ERR_BUF,
      ERR_RANGE, ERR_RANGE};
    for (int i = 0; i < 7; i++) begin
      pkw(op[i], id[i], 16'h0, lo[i]);
      check("rej flag", rsp[0][15], 1'b1);
      check("rej code", rsp[2], ec[i]);
    end
    pkw(16'h3, PAR_ID[IX_NODE], 16'h0, 16'h2);
    check("low node", rsp[2], ERR_RANGE);
    pkw(16'h4, PAR_ID[IX_NODE], 16'h4780, 16'h0);
    check("fl range", rsp[2], ERR_RANGE);
    pkw(16'h4, PAR_ID[IX_NODE], 16'h42c8, 16'h0);
    check("fl node", 16'(node), 16'h64);
    set(PAR_ID[IX_NODE], 16'h7f);
    check("node max", 16'(node), 16'h7f);
    set(PAR_ID[IX_IW3], 16'h15);
    check("iw3", 16'(iw3), 16'h15);
    set(PAR_ID[IX_IW4], 16'h44);
    check("iw4 set", 16'(iw4), 16'h44);
    set(PAR_ID[IX_MB_AREA], 16'h2);
    check("area set", 16'(mba), 16'h2);
  endtask

  task automatic t_link();
    cmd <= 16'h0401;
    ref_val <= 16'h1234;
    fb_run <= 1'b1;
    set(PAR_ID[IX_FREEZE], 16'h1);
    set(PAR_ID[IX_DELAY], 16'h5);
    set(PAR_ID[IX_FB_SEL], 16'h1);
    check("proto", 16'(fbp), 16'h1);
    repeat (30) @(posedge hclk);
    check("sref", sro, 16'h1234);
    fb_run <= 1'b0;
    repeat (60) @(posedge hclk);
    check("lost", 16'(fb_comm_lost), 16'h1);
    check("frozen", sro, 16'h1234);
    check("frozen cmd", cwo, 16'h0401);
    ref_val <= 16'h5678;
    fb_run <= 1'b1;
    repeat (40) @(posedge hclk);
    check("delay hold", sro, 16'h1234);
    repeat (120) @(posedge hclk);
    check("delay end", sro, 16'h5678);
    set(PAR_ID[IX_FREEZE], 16'h0);
    fb_run <= 1'b0;
    repeat (60) @(posedge hclk);
    check("no freeze", cwo, 16'h0);
  endtask

  task automatic t_modbus();
    mb_run <= 1'b1;
    set(PAR_ID[IX_MB_TMO], 16'h1);
    set(PAR_ID[IX_MB_EN], 16'h3);
    check("mb mode", 16'(mbm), 16'h3);
    repeat (2500) @(posedge hclk);
    check("mb quiet", 16'(mb_alarm53), 16'h0);
    mb_run <= 1'b0;
    repeat (2200) @(posedge hclk);
    check("mb alarm", 16'(mb_alarm53), 16'h1);
    set(PAR_ID[IX_MB_TMO], 16'h0);
    check("mb off", 16'(mb_alarm53), 16'h0);
  endtask

  task automatic t_layout();
    logic [31:0] q;
    set(PAR_ID[IX_LAYOUT], 16'h3);
    check("layout 3", 16'(lay), 16'h3);
    pkw(16'h1, PAR_ID[IX_NODE], 16'h0, 16'h0);
    check("no reply", rsp[1], PAR_ID[IX_LAYOUT]);
    bus(1'b0, A_STATUS, 32'h0, q);
    check("no done", 16'(q[ST_DONE]), 16'h0);
    check("no pkw", 16'(q[ST_PKW_EN]), 16'h0);
  endtask

  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    for (int i = 0; i < 40000; i++) @(posedge hclk);
    n_errors++;
    $display("[FAIL] cycle limit expected end seen hang");
    complete_run();
  end

  initial begin
    {hresetn, hsel, hwrite, fb_run, mb_run} = 5'h0;
    {haddr, hwdata} = 64'h0;
    htrans = 2'h0;
    cmd = 16'h0;
    ref_val = 16'h0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    hsel <= 1'b1;
    @(posedge hclk);
    t_reads();
    t_refuse();
    t_link();
    t_modbus();
    t_layout();
    complete_run();
  end
endmodule
`default_nettype wire
